//--- src/cdr_router.sv
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Lines 0-7 carry port bits only
// - Lines 32-39 carry counter signals only
// - Lines 8-31 may be port or counter
// - Output lines select port or counter individually
// - Gate/source lines drive selected gate/source
// - Counter 7 offers out 8, gate 10, source 11
// - Counter 6 offers out 12, gate 14, source 15
// - Counter 5 offers out 16, gate 18, source 19
// - Counter 4 offers out 20, gate 22, source 23
// - Counter 3 offers out 24, gate 26, source 27
// - Counter 2 offers out 28, gate 30, source 31
// - Four-counter variant drops counters 4-7
// - Slow and mid-rate timebases for every counter
// - Larger variants add the fast timebase
// - Each counter: gate, aux, source in, one out
// - External source edge-detected, rising or falling selectable
// - Active edge increments or decrements count
// - Selected source exportable on default source line
// - Exported outputs stay high-Z until enabled
// - Internal source from fast, mid or slow timebase
// - Output on rollover: pulse or toggle, polarity
module cdr_router
    import cdr_pkg::*;
#(
    parameter int NUM_CTR  = 8,  // 4 for the reduced variant
    parameter bit HAS_FAST = 1'b1
) (
    input  wire logic                clock_in,
    input  wire logic                resetn_in,
    input  wire logic                enable_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [31:0]         reg_wdata_in,
    input  wire logic                reg_write_in,
    input  wire logic                reg_read_in,
    output logic      [31:0]         reg_rdata_out,
    input  wire logic [LINES-1:0]    line_in,
    output logic      [LINES-1:0]    line_out,
    output logic      [LINES-1:0]    line_oe_out
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Counter that owns a line in 8..39
    function automatic int line_ctr(input int l);
        line_ctr = (CTR_LINE_BASE + CTR_LINE_STEP - 1 - l) / CTR_LINE_STEP;
    endfunction

    function automatic logic [1:0] line_role(input int l);
        line_role = 2'(l % CTR_LINE_STEP);
    endfunction

    // A shared line may carry a counter signal only if its counter exists
    function automatic logic alt_ok(input int l);
        alt_ok = (l > PORT_ONLY_TOP) && (line_role(l) != ROLE_AUX)
                 && (line_ctr(l) < NUM_CTR);
    endfunction

    // Out-of-range line numbers read low rather than X
    function automatic logic pick(input logic [LINES-1:0] v,
                                  input logic [LINE_IDX_W-1:0] idx);
        pick = (int'(idx) < LINES) ? v[idx] : 1'b0;
    endfunction

    // Default config routes each counter to its own group of lines
    function automatic logic [CFG_W-1:0] cfg_default(input int n);
        logic [CFG_W-1:0] c;
        c = '0;
        c[F_SLINE +: LINE_IDX_W] = LINE_IDX_W'(CTR_LINE_BASE - CTR_LINE_STEP*n + 3);
        c[F_GLINE +: LINE_IDX_W] = LINE_IDX_W'(CTR_LINE_BASE - CTR_LINE_STEP*n + 2);
        c[F_ALINE +: LINE_IDX_W] = LINE_IDX_W'(CTR_LINE_BASE - CTR_LINE_STEP*n + 1);
        cfg_default = c;
    endfunction

    // Fractional timebase step: ticks at hz on average from the system clock
    function automatic logic [31:0] tb_next(input logic [31:0] acc, input int hz);
        tb_next = (acc + 32'(hz) >= 32'(CLK_HZ)) ? acc + 32'(hz) - 32'(CLK_HZ)
                                                 : acc + 32'(hz);
    endfunction

    function automatic logic tb_hit(input logic [31:0] acc, input int hz);
        tb_hit = (acc + 32'(hz) >= 32'(CLK_HZ));
    endfunction

    // Shared-line mask, computed once from the variant
    function automatic logic [PORT_W-1:0] sel_mask();
        logic [PORT_W-1:0] m;
        m = '0;
        for (int l = 0; l < PORT_W; l++) begin
            m[l] = alt_ok(l);
        end
        sel_mask = m;
    endfunction

    localparam logic [PORT_W-1:0] SEL_MASK = sel_mask();
    // Lines 33 and 37 are inputs only
    localparam logic [HI_LINES-1:0] HI_MASK = 8'hDD;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [PORT_W-1:0]   port_data;
    logic [PORT_W-1:0]   port_dir;
    logic [PORT_W-1:0]   line_sel;
    logic [HI_LINES-1:0] hi_en;
    logic [CFG_W-1:0]    cfg      [MAX_CTR];
    logic [31:0]         count    [MAX_CTR];
    logic [MAX_CTR-1:0]  src_prev;
    logic [MAX_CTR-1:0]  out_lvl;
    logic [31:0]         acc_slow;
    logic [31:0]         acc_mid;
    logic [31:0]         acc_fast;
    logic [2:0]          tb_tick;
    logic [2:0]          tb_lvl;

    logic [MAX_CTR-1:0]  src_sig;
    logic [MAX_CTR-1:0]  gate_sig;
    logic [MAX_CTR-1:0]  aux_sig;
    logic [MAX_CTR-1:0]  src_edge;
    logic [MAX_CTR-1:0]  term;
    logic [31:0]         next_count [MAX_CTR];
    logic [LINES-1:0]    next_line;
    logic [LINES-1:0]    next_oe;
    logic [31:0]         next_rdata;

    // ----------------------------------------------------------------
    // Internal timebases
    // ----------------------------------------------------------------
    // slow, mid and fast; fast stays zero without HAS_FAST
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc_slow <= 32'h0;
            acc_mid  <= 32'h0;
            acc_fast <= 32'h0;
            tb_tick  <= 3'h0;
        end else if (enable_in) begin
            acc_slow   <= tb_next(acc_slow, SLOW_HZ);
            acc_mid    <= tb_next(acc_mid, MID_HZ);
            tb_tick[0] <= tb_hit(acc_slow, SLOW_HZ);
            tb_tick[1] <= tb_hit(acc_mid, MID_HZ);
            acc_fast   <= HAS_FAST ? tb_next(acc_fast, FAST_HZ) : 32'h0;
            tb_tick[2] <= HAS_FAST && tb_hit(acc_fast, FAST_HZ);
        end
    end

    // Square-wave copies so an exported timebase is visible on a pin
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tb_lvl <= 3'h0;
        end else if (enable_in) begin
            tb_lvl <= tb_lvl ^ tb_tick;
        end
    end

    // ----------------------------------------------------------------
    // Counter input selection and edge detection
    // ----------------------------------------------------------------
    always_comb begin
        src_sig  = '0;
        gate_sig = '0;
        aux_sig  = '0;
        src_edge = '0;
        for (int n = 0; n < MAX_CTR; n++) begin
            // gate, aux and source from any line
            gate_sig[n] = pick(line_in, cfg[n][F_GLINE +: LINE_IDX_W]);
            aux_sig[n]  = pick(line_in, cfg[n][F_ALINE +: LINE_IDX_W]);
            case (cdr_src_t'(cfg[n][F_SRC_HI:F_SRC_LO]))
                CDR_SRC_SLOW: begin
                    src_sig[n]  = tb_lvl[0];
                    src_edge[n] = tb_tick[0];
                end
                CDR_SRC_MID: begin
                    src_sig[n]  = tb_lvl[1];
                    src_edge[n] = tb_tick[1];
                end
                CDR_SRC_FAST: begin
                    src_sig[n]  = tb_lvl[2];
                    src_edge[n] = tb_tick[2];
                end
                default: begin
                    src_sig[n] = pick(line_in, cfg[n][F_SLINE +: LINE_IDX_W]);
                    src_edge[n] = cfg[n][F_FALL] ? (src_prev[n] && !src_sig[n])
                                                 : (!src_prev[n] && src_sig[n]);
                end
            endcase
        end
    end

    // Previous source level for external edge detection
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            src_prev <= '0;
        end else if (enable_in) begin
            src_prev <= src_sig;
        end
    end

    // ----------------------------------------------------------------
    // Counting
    // ----------------------------------------------------------------
    always_comb begin
        term = '0;
        for (int n = 0; n < MAX_CTR; n++) begin
            next_count[n] = count[n];
            if (n < NUM_CTR && cfg[n][F_ENABLE]) begin
                if (cfg[n][F_ENC]) begin
                    if (gate_sig[n]) begin
                        next_count[n] = 32'h0;
                    end else if (src_edge[n]) begin
                        next_count[n] = aux_sig[n] ? count[n] - 32'h1 : count[n] + 32'h1;
                        term[n] = aux_sig[n] ? (count[n] == 32'h0)
                                             : (count[n] == 32'hFFFFFFFF);
                    end
                end else if (src_edge[n] && (!cfg[n][F_GATED] || gate_sig[n])) begin
                    // count up or down per edge
                    if (cfg[n][F_DOWN] || (cfg[n][F_AUXDIR] && aux_sig[n])) begin
                        next_count[n] = count[n] - 32'h1;
                        term[n] = (count[n] == 32'h0);
                    end else begin
                        next_count[n] = count[n] + 32'h1;
                        term[n] = (count[n] == 32'hFFFFFFFF);
                    end
                end
            end
        end
    end

    // Count registers; a software write takes priority over counting
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int n = 0; n < MAX_CTR; n++) begin
                count[n] <= 32'h0;
            end
        end else if (enable_in) begin
            for (int n = 0; n < MAX_CTR; n++) begin
                if (reg_write_in && reg_addr_in == ADDR_CNT_BASE + 8'(4*n)
                    && n < NUM_CTR) begin
                    count[n] <= reg_wdata_in;
                end else begin
                    count[n] <= next_count[n];
                end
            end
        end
    end

    // Terminal-count output: one-cycle pulse or toggle, then polarity
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            out_lvl <= '0;
        end else if (enable_in) begin
            for (int n = 0; n < MAX_CTR; n++) begin
                if (cfg[n][F_TOGGLE]) begin
                    out_lvl[n] <= out_lvl[n] ^ term[n];
                end else begin
                    out_lvl[n] <= term[n];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_data <= 32'h0;
            port_dir  <= 32'h0;
            line_sel  <= 32'h0;
            hi_en     <= 8'h0;
        end else if (enable_in && reg_write_in) begin
            if (reg_addr_in == ADDR_PORT_DATA) begin
                port_data <= reg_wdata_in;
            end else if (reg_addr_in == ADDR_PORT_DIR) begin
                port_dir <= reg_wdata_in;
            end else if (reg_addr_in == ADDR_LINE_SEL) begin
                line_sel <= reg_wdata_in & SEL_MASK;
            end else if (reg_addr_in == ADDR_HI_EN) begin
                hi_en <= reg_wdata_in[HI_LINES-1:0] & HI_MASK;
            end
        end
    end

    // Counter configs; absent counters hold their reset value
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int n = 0; n < MAX_CTR; n++) begin
                cfg[n] <= cfg_default(n);
            end
        end else if (enable_in && reg_write_in) begin
            for (int n = 0; n < MAX_CTR; n++) begin
                if (reg_addr_in == ADDR_CFG_BASE + 8'(4*n) && n < NUM_CTR) begin
                    cfg[n] <= reg_wdata_in[CFG_W-1:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Line output multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        next_line = '0;
        next_oe   = '0;
        for (int l = 0; l < LINES; l++) begin
            if (l <= SHARED_TOP && !(line_sel[l] && alt_ok(l))) begin
                // port use, driven when its direction bit is set
                next_line[l] = port_data[l];
                next_oe[l]   = port_dir[l];
            end else if (l > PORT_ONLY_TOP) begin
                // counter use of a shared line, or a high line
                // counters 0 and 1 on the high lines
                case (line_role(l))
                    ROLE_OUT:  next_line[l] = out_lvl[line_ctr(l)]
                                              ^ cfg[line_ctr(l)][F_INV];
                    ROLE_GATE: next_line[l] = gate_sig[line_ctr(l)];
                    ROLE_SRC:  next_line[l] = src_sig[line_ctr(l)];
                    default:   next_line[l] = 1'b0;
                endcase
                // high-Z until software enables the line
                if (l > SHARED_TOP) begin
                    // high lines never carry port bits
                    next_oe[l] = hi_en[l - SHARED_TOP - 1];
                end else begin
                    next_oe[l] = port_dir[l];
                end
            end
        end
    end

    // Pins come straight from flops; adds one cycle of latency
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            line_out    <= '0;
            line_oe_out <= '0;
        end else if (enable_in) begin
            line_out    <= next_line;
            line_oe_out <= next_oe;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0;
        if (reg_addr_in == ADDR_PORT_DATA) begin
            next_rdata = port_data;
        end else if (reg_addr_in == ADDR_PORT_IN) begin
            next_rdata = line_in[PORT_W-1:0];
        end else if (reg_addr_in == ADDR_PORT_DIR) begin
            next_rdata = port_dir;
        end else if (reg_addr_in == ADDR_LINE_SEL) begin
            next_rdata = line_sel;
        end else if (reg_addr_in == ADDR_HI_EN) begin
            next_rdata = {24'h0, hi_en};
        end else if (reg_addr_in == ADDR_HI_IN) begin
            next_rdata = {24'h0, line_in[LINES-1:PORT_W]};
        end else if (reg_addr_in[7:5] == CTR_REGION_CFG && reg_addr_in[1:0] == 2'h0
                     && int'(reg_addr_in[4:2]) < NUM_CTR) begin
            next_rdata = {4'h0, cfg[reg_addr_in[4:2]]};
        end else if (reg_addr_in[7:5] == CTR_REGION_CNT && reg_addr_in[1:0] == 2'h0
                     && int'(reg_addr_in[4:2]) < NUM_CTR) begin
            next_rdata = count[reg_addr_in[4:2]];
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 32'h0;
        end else if (enable_in) begin
            reg_rdata_out <= reg_read_in ? next_rdata : 32'h0;
        end
    end

endmodule

//--- src/cdr_pkg.sv
package cdr_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int LINES      = 40;
    localparam int MAX_CTR    = 8;
    localparam int PORT_W     = 32;
    localparam int LINE_IDX_W = 6;
    localparam int PORT_ONLY_TOP  = 7;   // Lines 0..7: port only
    localparam int SHARED_TOP     = 31;  // Lines 8..31: port or counter
    localparam int CTR_LINE_BASE  = 36;  // Counter n group starts at 36 - 4n
    localparam int CTR_LINE_STEP  = 4;
    localparam int HI_LINES       = 8;   // Lines 32..39

    // Role of a line inside its counter group (line mod 4)
    localparam logic [1:0] ROLE_OUT  = 2'h0;
    localparam logic [1:0] ROLE_AUX  = 2'h1;
    localparam logic [1:0] ROLE_GATE = 2'h2;
    localparam logic [1:0] ROLE_SRC  = 2'h3;

    // ----------------------------------------------------------------
    // Timebases
    // ----------------------------------------------------------------
    localparam int CLK_HZ  = 100_000_000;
    localparam int SLOW_HZ = 100_000;
    localparam int MID_HZ  = 20_000_000;
    localparam int FAST_HZ = 80_000_000;

    typedef enum logic [1:0] {
        CDR_SRC_SLOW = 2'b00,
        CDR_SRC_MID  = 2'b01,
        CDR_SRC_FAST = 2'b10,
        CDR_SRC_EXT  = 2'b11
    } cdr_src_t;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_DATA = 8'h00;
    localparam logic [7:0] ADDR_PORT_IN   = 8'h04;
    localparam logic [7:0] ADDR_PORT_DIR  = 8'h08;
    localparam logic [7:0] ADDR_LINE_SEL  = 8'h0C;
    localparam logic [7:0] ADDR_HI_EN     = 8'h10;
    localparam logic [7:0] ADDR_HI_IN     = 8'h14;
    localparam logic [7:0] ADDR_CFG_BASE  = 8'h40;
    localparam logic [7:0] ADDR_CNT_BASE  = 8'h80;
    localparam logic [2:0] CTR_REGION_CFG = 3'h2;  // addr[7:5]
    localparam logic [2:0] CTR_REGION_CNT = 3'h4;

    // Counter config fields
    localparam int F_SRC_LO  = 0;
    localparam int F_SRC_HI  = 1;
    localparam int F_FALL    = 2;
    localparam int F_DOWN    = 3;
    localparam int F_TOGGLE  = 4;
    localparam int F_INV     = 5;
    localparam int F_ENABLE  = 6;
    localparam int F_ENC     = 7;
    localparam int F_AUXDIR  = 8;
    localparam int F_GATED   = 9;
    localparam int F_SLINE   = 10;
    localparam int F_GLINE   = 16;
    localparam int F_ALINE   = 22;
    localparam int CFG_W     = 28;
endpackage

//--- testbench/cdr_router_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the line router
// ----------------------------------------------------------------
module cdr_router_checker
    import cdr_pkg::*;
#(
    parameter int NUM_CTR = 8
) (
    input  wire logic             clock_in,
    input  wire logic             resetn_in,
    input  wire logic             enable_in,
    input  wire logic [7:0]       reg_addr_in,
    input  wire logic [31:0]      reg_wdata_in,
    input  wire logic             reg_write_in,
    input  wire logic             reg_read_in,
    input  wire logic [31:0]      reg_rdata_out,
    input  wire logic [LINES-1:0] line_in,
    input  wire logic [LINES-1:0] line_out,
    input  wire logic [LINES-1:0] line_oe_out
);
    // Aux lines and absent counters can never take a counter signal
    localparam logic [31:0] SEL_OK = (NUM_CTR == 4) ? 32'hDD000000 : 32'hDDDDDD00;
    logic [31:0] dat;
    logic [31:0] dir;
    logic [31:0] sel;
    logic [7:0]  hien;
    logic [5:0]  cfg0;

    // Shadows of software writes; outputs are judged against these
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dat <= 32'h0;
            dir <= 32'h0;
            sel <= 32'h0;
            hien <= 8'h0;
            cfg0 <= 6'h0;
        end else if (enable_in && reg_write_in) begin
            case (reg_addr_in)
                ADDR_PORT_DATA: dat <= reg_wdata_in;
                ADDR_PORT_DIR:  dir <= reg_wdata_in;
                ADDR_LINE_SEL:  sel <= reg_wdata_in;
                ADDR_HI_EN:     hien <= reg_wdata_in[7:0];
                ADDR_CFG_BASE:  cfg0 <= reg_wdata_in[5:0];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    a_low_port_oe: assert property (
        $past(enable_in) |-> line_oe_out[7:0] == $past(dir[7:0]))
        else $error("low line enable differs from port direction");
    a_low_port_data: assert property (
        $past(enable_in) |-> ((line_out[7:0] ^ $past(dat[7:0])) & line_oe_out[7:0]) == 8'h00)
        else $error("low line carries something other than its port bit");
    a_input_only: assert property (
        !line_oe_out[33] && !line_oe_out[37])
        else $error("input only line driven");
    a_hi_enable: assert property (
        $past(enable_in) |-> line_oe_out[39:32] == ($past(hien) & 8'hDD))
        else $error("upper line enable wrong");
    a_mid_enable: assert property (
        $past(enable_in) |-> line_oe_out[31:8] == $past(dir[31:8]))
        else $error("shared line enable wrong");
    a_mid_port: assert property (
        $past(enable_in) |-> ((line_out[31:8] ^ $past(dat[31:8])) & line_oe_out[31:8]
        & ~$past(sel[31:8] & SEL_OK[31:8])) == 24'h0)
        else $error("shared port line carries wrong level");
    a_pulse_once: assert property (
        line_oe_out[36] && line_out[36] && cfg0[5:4] == 2'b00 && $past(cfg0[5:4]) == 2'b00
        |=> !line_out[36])
        else $error("pulse output longer than one cycle");
    a_src_export: assert property (
        line_oe_out[39] && cfg0[1:0] == 2'b01 && $past(cfg0[1:0]) == 2'b01
        |-> ##[1:6] (line_out[39] != $past(line_out[39])))
        else $error("exported mid rate source not moving");

    c_pulse: cover property (line_oe_out[36] && line_out[36]);
    c_export: cover property (line_oe_out[39] && $rose(line_out[39]));
    c_read: cover property ($past(reg_read_in) && reg_rdata_out != 32'h0);
endmodule

bind cdr_router cdr_router_checker #(.NUM_CTR(NUM_CTR)) u_chk (
    .clock_in(clock_in), .resetn_in(resetn_in), .enable_in(enable_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .line_in(line_in), .line_out(line_out),
    .line_oe_out(line_oe_out));

//--- testbench/cdr_field_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Field wiring at the function lines
// ----------------------------------------------------------------
module cdr_field_model
    import cdr_pkg::*;
(
    input  wire logic [LINES-1:0] dev_out_in,
    input  wire logic [LINES-1:0] dev_oe_in,
    input  wire logic [LINES-1:0] field_in,
    output logic      [LINES-1:0] line_level_out
);
    // A driven line reads back the device; the field only wins when undriven
    assign line_level_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & field_in);
endmodule

//--- testbench/counter_dio_line_router_test.sv
`timescale 1ns/1ps
module counter_dio_line_router_test;
    import cdr_pkg::*;
    localparam logic [31:0] CFG_LINES = (32'h25 << 22) | (32'h26 << 16) | (32'h27 << 10);
    logic        clock_in;
    logic        resetn_in;
    logic        enable_in;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic [39:0] field;
    logic [39:0] lvl;
    logic [39:0] lout;
    logic [39:0] loe;
    logic        held;
    int          mismatches;
    int          tests_run;

    cdr_router #(.NUM_CTR(8), .HAS_FAST(1'b1)) u_dut (
        .clock_in(clock_in), .resetn_in(resetn_in), .enable_in(enable_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
        .reg_read_in(reg_read), .reg_rdata_out(reg_rdata), .line_in(lvl),
        .line_out(lout), .line_oe_out(loe));
    cdr_field_model u_field (.dev_out_in(lout), .dev_oe_in(loe), .field_in(field),
        .line_level_out(lvl));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock_in);
        reg_write <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_in);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock_in);
        reg_read <= 1'b0;
        #1 chk(40'(reg_rdata), 40'(e));
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic drv(input int i, input logic v);
        @(posedge clock_in);
        field[i] <= v;
    endtask
    // Bounded wait for a line to move away from its present level
    task automatic see_change(input int i, input int lim);
        logic old;
        int   k;
        old = lout[i];
        k = 0;
        while (lout[i] === old && k < lim) begin
            step(1);
            k++;
        end
        chk(40'(lout[i] !== old), 40'h1);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // Whole run is a few thousand cycles; slow timebase dominates
    initial begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        wrap_up;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        resetn_in = 1'b0;
        enable_in = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        field = 40'h0;
        mismatches = 0;
        tests_run = 0;
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        #1 chk(loe, 40'h0);
        rd(ADDR_CFG_BASE, CFG_LINES);
        rd(ADDR_HI_EN, 32'h0);
        wr(ADDR_PORT_DIR, 32'hFFFFFFFF);
        wr(ADDR_PORT_DATA, 32'hA5A5A5A5);
        step(2);
        chk(loe, 40'h00FFFFFFFF);
        chk(40'(lout[31:0]), 40'hA5A5A5A5);
        // Frozen block ignores a write
        @(posedge clock_in);
        enable_in <= 1'b0;
        wr(ADDR_PORT_DATA, 32'h0);
        @(posedge clock_in);
        enable_in <= 1'b1;
        rd(ADDR_PORT_DATA, 32'hA5A5A5A5);
        wr(ADDR_LINE_SEL, 32'hFFFFFFFF);
        rd(ADDR_LINE_SEL, 32'hDDDDDD00);
        step(2);
        chk(40'(lout[31:0] & 32'h11111100), 40'h0);
        for (int n = 2; n < 8; n++) begin
            wr(ADDR_CFG_BASE + 8'(4 * n), 32'h20);
        end
        step(2);
        chk(40'(lout[31:0] & 32'h11111100), 40'h11111100);
        wr(ADDR_LINE_SEL, 32'h0);
        step(2);
        chk(40'(lout[31:0]), 40'hA5A5A5A5);
        wr(ADDR_HI_EN, 32'hFF);
        rd(ADDR_HI_EN, 32'hDD);
        step(2);
        chk(40'(loe[39:32]), 40'hDD);
        // Counter zero edge counting through its output line
        wr(ADDR_HI_EN, 32'h10);
        wr(ADDR_CFG_BASE, CFG_LINES | 32'h43);
        wr(ADDR_CNT_BASE, 32'hFFFFFFFF);
        drv(39, 1'b1);
        see_change(36, 6);
        step(1);
        chk(40'(lout[36]), 40'h0);
        rd(ADDR_CNT_BASE, 32'h0);
        wr(ADDR_CFG_BASE, CFG_LINES | 32'h4F);
        wr(ADDR_CNT_BASE, 32'h0);
        drv(39, 1'b0);
        see_change(36, 6);
        rd(ADDR_CNT_BASE, 32'hFFFFFFFF);
        wr(ADDR_CFG_BASE, CFG_LINES | 32'h5F);
        wr(ADDR_CNT_BASE, 32'h0);
        drv(39, 1'b1);
        drv(39, 1'b0);
        see_change(36, 8);
        held = lout[36];
        step(4);
        chk(40'(lout[36]), 40'(held));
        // Encoder: A on source line, B on aux, index on gate
        wr(ADDR_CFG_BASE, CFG_LINES | 32'hC3);
        wr(ADDR_CNT_BASE, 32'h5);
        drv(37, 1'b1);
        drv(39, 1'b1);
        step(3);
        rd(ADDR_CNT_BASE, 32'h4);
        drv(38, 1'b1);
        step(3);
        rd(ADDR_CNT_BASE, 32'h0);
        drv(38, 1'b0);
        // Exported source from each internal timebase
        wr(ADDR_HI_EN, 32'h80);
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_CFG_BASE, CFG_LINES | 32'h40 | 32'(s));
            see_change(39, 1100);
            see_change(39, 1100);
        end
        chk(40'(loe[39:32]), 40'h80);
        wr(8'h30, 32'hFFFFFFFF);
        rd(8'h30, 32'h0);
        wrap_up;
    end
endmodule
